// ### acc_regs.svh
`ifndef ACC_REGS_SVH
`define ACC_REGS_SVH
// register byte offsets
`define ACC_OFS_INSEL     12'h008
`define ACC_OFS_ACCUM     12'h00C
`define ACC_OFS_RESULT    12'h010
`define ACC_OFS_STATUS    12'h014
// reset values
`define ACC_INSEL_RST     16'h0000
`define ACC_ACCUM_RST     8'h00
// field positions
`define ACC_NEG_HI        12
`define ACC_NEG_LO        8
`define ACC_POS_HI        4
`define ACC_POS_LO        0
`define ACC_DIV_HI        6
`define ACC_DIV_LO        4
`define ACC_CNT_HI        3
`define ACC_CNT_LO        0
// selection codes
`define ACC_PIN_MAX       5'h05
`define ACC_SEL_GND       5'h18
`define ACC_CNT_MAX       4'hA
`endif

// ### acc_pkg.sv
package acc_pkg;
  typedef enum logic [1:0] {
    ACC_IDLE = 2'b01,
    ACC_RUN  = 2'b10
  } acc_state_e;
  // converter sample handshake
  typedef struct packed {
    logic        valid;
    logic [11:0] data;
  } acc_sample_s;
  // mux selection to the analog core
  typedef struct packed {
    logic [4:0] pos;
    logic [4:0] neg;
    logic       pos_ok;
    logic       neg_ok;
  } acc_mux_s;
endpackage

// ### acc_avg.sv
// The APB slave port is this design's own decision.
`timescale 1ns/1ns
`include "acc_regs.svh"
module acc_avg
  import acc_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // converter core
  input  wire acc_sample_s sample,
  output acc_mux_s         mux_sel
);

  logic [15:0] insel_q, insel_d;
  logic [7:0]  avg_q, avg_d;
  logic [21:0] acc_q, acc_d;
  logic [10:0] cnt_q, cnt_d;
  logic [21:0] res_q, res_d;
  logic        done_q, done_d;
  acc_state_e  st_q, st_d;
  logic [31:0] rd_q, rd_d;
  logic        rdy_q, rdy_d, err_q, err_d;
  acc_mux_s    mux_q, mux_d;
  logic        acc_ok;
  logic [21:0] sum;
  logic [10:0] target;
  logic [3:0]  cfg_cnt;
  logic [2:0]  cfg_div;
  logic        wr, rd, hit, acs_first;

  // answer in the cycle after the first access cycle, commit a write on the completing edge
  assign acs_first = psel && penable && !rdy_q;
  assign wr      = psel && penable && pwrite && rdy_q;
  assign rd      = acs_first && !pwrite;
  assign cfg_cnt = avg_q[`ACC_CNT_HI:`ACC_CNT_LO];
  assign cfg_div = avg_q[`ACC_DIV_HI:`ACC_DIV_LO];
  assign acc_ok  = cfg_cnt <= `ACC_CNT_MAX;
  assign target  = acc_ok ? 11'(11'h001 << cfg_cnt) : 11'h001;
  assign sum     = acc_q + {10'h000, sample.data};

  // register file and bus answer
  always_comb begin
    insel_d = insel_q;
    avg_d   = avg_q;
    rd_d    = 32'h0000_0000;
    rdy_d   = acs_first;
    err_d   = 1'b0;
    hit     = 1'b1;
    unique case (paddr)
      `ACC_OFS_INSEL: begin
        if (wr) insel_d = pwdata[15:0] & 16'h1F1F;
        rd_d = {16'h0000, insel_q};
      end
      `ACC_OFS_ACCUM: begin
        if (wr) avg_d = pwdata[7:0] & 8'h7F;
        rd_d = {24'h000000, avg_q};
      end
      `ACC_OFS_RESULT:  rd_d = {10'h000, res_q};
      `ACC_OFS_STATUS:  rd_d = {30'h0, st_q == ACC_RUN, done_q};
      default:          hit = 1'b0;
    endcase
    if (!rd) rd_d = 32'h0000_0000;
    if (acs_first && !hit) err_d = 1'b1;
  end

  // mux routing decode
  always_comb begin
    mux_d.pos    = insel_q[`ACC_POS_HI:`ACC_POS_LO];
    mux_d.neg    = insel_q[`ACC_NEG_HI:`ACC_NEG_LO];
    mux_d.pos_ok = mux_d.pos <= `ACC_PIN_MAX;
    mux_d.neg_ok = (mux_d.neg <= `ACC_PIN_MAX) ||
                   (mux_d.neg == `ACC_SEL_GND);
  end

  // accumulation and division
  always_comb begin
    st_d   = st_q;
    acc_d  = acc_q;
    cnt_d  = cnt_q;
    res_d  = res_q;
    done_d = done_q;
    if (rd && paddr == `ACC_OFS_RESULT) done_d = 1'b0;
    unique case (st_q)
      ACC_IDLE: begin
        if (sample.valid) begin
          if (target == 11'h001) begin
            res_d  = {10'h000, sample.data} >> cfg_div;
            done_d = 1'b1;
          end else begin
            acc_d = {10'h000, sample.data};
            cnt_d = 11'h001;
            st_d  = ACC_RUN;
          end
        end
      end
      ACC_RUN: begin
        if (sample.valid) begin
          if (cnt_q + 11'h001 >= target) begin
            res_d  = sum >> cfg_div;
            done_d = 1'b1;
            st_d   = ACC_IDLE;
          end else begin
            acc_d = sum;
            cnt_d = cnt_q + 11'h001;
          end
        end
      end
      default: st_d = ACC_IDLE;
    endcase
  end

  // state registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      insel_q <= `ACC_INSEL_RST;
      avg_q   <= `ACC_ACCUM_RST;
      acc_q   <= 22'h000000;
      cnt_q   <= 11'h000;
      res_q   <= 22'h000000;
      done_q  <= 1'b0;
      st_q    <= ACC_IDLE;
      rd_q    <= 32'h0000_0000;
      rdy_q   <= 1'b0;
      err_q   <= 1'b0;
      mux_q   <= '0;
    end else begin
      insel_q <= insel_d;
      avg_q   <= avg_d;
      acc_q   <= acc_d;
      cnt_q   <= cnt_d;
      res_q   <= res_d;
      done_q  <= done_d;
      st_q    <= st_d;
      rd_q    <= rd_d;
      rdy_q   <= rdy_d;
      err_q   <= err_d;
      mux_q   <= mux_d;
    end
  end

  assign prdata  = rd_q;
  assign pready  = rdy_q;
  assign pslverr = err_q;
  assign mux_sel = mux_q;

  // checks
  property p_neg_route;
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> mux_sel.neg == $past(insel_q[12:8]);
  endproperty
  a_neg_route: assert property (p_neg_route)
    else $error("negative select mismatch");

  property p_gnd_ok;
    @(posedge pclk) disable iff (!presetn)
    insel_q[12:8] == 5'h18 |=> mux_sel.neg_ok;
  endproperty
  a_gnd_ok: assert property (p_gnd_ok)
    else $error("ground select not valid");

  property p_pos_range;
    @(posedge pclk) disable iff (!presetn)
    insel_q[4:0] > 5'h05 |=> !mux_sel.pos_ok;
  endproperty
  a_pos_range: assert property (p_pos_range)
    else $error("reserved positive code flagged valid");

  property p_single_shift;
    @(posedge pclk) disable iff (!presetn)
    st_q == ACC_IDLE && sample.valid && avg_q[3:0] == 4'h0 |=>
      res_q == ($past({10'h000, sample.data}) >> $past(avg_q[6:4]));
  endproperty
  a_single_shift: assert property (p_single_shift)
    else $error("single sample result wrong");

  property p_cnt_bound;
    @(posedge pclk) disable iff (!presetn)
    st_q == ACC_RUN |-> cnt_q < target;
  endproperty
  a_cnt_bound: assert property (p_cnt_bound)
    else $error("sample count overran target");

  property p_done_set;
    @(posedge pclk) disable iff (!presetn)
    st_q == ACC_RUN && sample.valid && cnt_q + 11'h001 >= target
      |=> done_q && st_q == ACC_IDLE;
  endproperty
  a_done_set: assert property (p_done_set)
    else $error("result not posted");

  property p_shift_run;
    @(posedge pclk) disable iff (!presetn)
    st_q == ACC_RUN && sample.valid && cnt_q + 11'h001 >= target
      |=> res_q == ($past(sum) >> $past(avg_q[6:4]));
  endproperty
  a_shift_run: assert property (p_shift_run)
    else $error("accumulated result shift wrong");

  property p_ready_pulse;
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready held two cycles");

  property p_pos_route;
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> mux_sel.pos == $past(insel_q[`ACC_POS_HI:`ACC_POS_LO]);
  endproperty
  a_pos_route: assert property (p_pos_route)
    else $error("positive select mismatch");

  property p_pos_pin;
    @(posedge pclk) disable iff (!presetn)
    insel_q[`ACC_POS_HI:`ACC_POS_LO] <= `ACC_PIN_MAX |=> mux_sel.pos_ok;
  endproperty
  a_pos_pin: assert property (p_pos_pin)
    else $error("pin positive code flagged reserved");

  // codes between the last pin and ground, and above ground, are reserved
  property p_neg_reserved;
    @(posedge pclk) disable iff (!presetn)
    insel_q[`ACC_NEG_HI:`ACC_NEG_LO] > `ACC_PIN_MAX &&
      insel_q[`ACC_NEG_HI:`ACC_NEG_LO] != `ACC_SEL_GND |=> !mux_sel.neg_ok;
  endproperty
  a_neg_reserved: assert property (p_neg_reserved)
    else $error("reserved negative code flagged valid");

  // reserved count codes behave as a single sample
  property p_reserved_count;
    @(posedge pclk) disable iff (!presetn)
    st_q == ACC_IDLE && sample.valid && !acc_ok
      |=> done_q && st_q == ACC_IDLE;
  endproperty
  a_reserved_count: assert property (p_reserved_count)
    else $error("reserved count code not taken as one sample");

  // first sample of a longer run loads the accumulator
  property p_first_acc;
    @(posedge pclk) disable iff (!presetn)
    st_q == ACC_IDLE && sample.valid && target != 11'h001
      |=> st_q == ACC_RUN && cnt_q == 11'h001 &&
          acc_q == $past({10'h000, sample.data});
  endproperty
  a_first_acc: assert property (p_first_acc)
    else $error("first sample not loaded");

  property p_run_acc;
    @(posedge pclk) disable iff (!presetn)
    st_q == ACC_RUN && sample.valid && cnt_q + 11'h001 < target
      |=> acc_q == $past(sum) && cnt_q == $past(cnt_q) + 11'h001;
  endproperty
  a_run_acc: assert property (p_run_acc)
    else $error("sample not added to the sum");

  // done stands until the result register is read
  property p_done_hold;
    @(posedge pclk) disable iff (!presetn)
    done_q && !(rd && paddr == `ACC_OFS_RESULT) |=> done_q;
  endproperty
  a_done_hold: assert property (p_done_hold)
    else $error("done dropped without a result read");

  property p_result_hold;
    @(posedge pclk) disable iff (!presetn)
    !sample.valid |=> $stable(res_q);
  endproperty
  a_result_hold: assert property (p_result_hold)
    else $error("result changed without a sample");

  // bus answer: one wait state, error with it, data only while ready
  property p_ready_answer;
    @(posedge pclk) disable iff (!presetn)
    psel && penable && !pready |=> pready;
  endproperty
  a_ready_answer: assert property (p_ready_answer)
    else $error("pready missing after one wait state");

  property p_err_unmapped;
    @(posedge pclk) disable iff (!presetn)
    acs_first && !hit |=> pslverr && pready;
  endproperty
  a_err_unmapped: assert property (p_err_unmapped)
    else $error("unmapped address answered without error");

  property p_rd_idle;
    @(posedge pclk) disable iff (!presetn)
    !pready |-> prdata == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside the ready cycle");

  property p_write_commit;
    @(posedge pclk) disable iff (!presetn)
    wr && paddr == `ACC_OFS_INSEL
      |=> insel_q == ($past(pwdata[15:0]) & 16'h1F1F);
  endproperty
  a_write_commit: assert property (p_write_commit)
    else $error("input select write lost");

  // main scenarios
  c_gnd: cover property (@(posedge pclk) mux_sel.neg == 5'h18);
  c_run: cover property (@(posedge pclk) st_q == ACC_RUN ##1 done_q);
  c_err: cover property (@(posedge pclk) pslverr);
  c_reserved: cover property (@(posedge pclk) sample.valid && !acc_ok);
  c_long: cover property (@(posedge pclk) done_q && cfg_cnt == `ACC_CNT_MAX);
endmodule

// ### acc_core_model.sv
`timescale 1ns/1ns
module acc_core_model
  import acc_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // burst request from the bench
  input  wire logic        go,
  input  wire logic [10:0] count,
  input  wire logic [11:0] base,
  // converter side
  input  wire acc_mux_s    mux_sel,
  output acc_sample_s      sample
);
  logic [10:0] left_q;
  logic [11:0] idx_q;
  // back-to-back samples base+i; data line scrambles while idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_q <= '0;
      idx_q  <= '0;
      sample <= '0;
    end else if (go) begin
      left_q       <= count;
      idx_q        <= '0;
      sample.valid <= 1'b0;
    end else if (left_q != 11'h000) begin
      sample.valid <= 1'b1;
      sample.data  <= base + idx_q;
      idx_q        <= idx_q + 12'h001;
      left_q       <= left_q - 11'h001;
    end else begin
      sample.valid <= 1'b0;
      sample.data  <= ~sample.data;
    end
  end
endmodule

// ### tb.sv
`timescale 1ns/1ns
`include "acc_regs.svh"
module tb;
  import acc_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        go = 0, pready, pslverr, er;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [10:0] cnt = '0;
  acc_sample_s sample;
  acc_mux_s    mux_sel;
  int          errors = 0, checks = 0;
  // design and converter model
  acc_avg i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample(sample),
    .mux_sel(mux_sel));
  acc_core_model i_core (.pclk(pclk), .presetn(presetn), .go(go),
    .count(cnt), .base(12'h800), .mux_sel(mux_sel), .sample(sample));
  always #25 pclk = ~pclk;
  task print_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer, held until pready is sampled high at a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (pready !== 1'b1) begin
      errors++;
      print_verdict();
    end
  endtask
  task t_reset();
    apb(0, `ACC_OFS_INSEL, '0);   chk(rd, 32'h0000_0000);
    apb(0, `ACC_OFS_ACCUM, '0);   chk(rd, 32'h0000_0000);
    apb(1, 12'h040, 32'hFFFF_FFFF); chk(er, 1'b1);
    apb(0, 12'h040, '0); chk(er, 1'b1);
    chk(rd, 32'h0000_0000);
    $display("test reset done");
  endtask
  task t_mux();
    logic [4:0] negs [3];
    logic [4:0] poss [3];
    negs = '{5'h05, 5'h18, 5'h19};
    // pin codes 0 and 5 and reserved code 6 on the positive side, so no sampling time to set
    poss = '{5'h00, 5'h05, 5'h06};
    for (int i = 0; i < 3; i++) begin
      apb(1, `ACC_OFS_INSEL, {19'h0, negs[i], 3'h0, poss[i]});
      // routing follows one cycle after the register
      repeat (2) @(posedge pclk);
      chk(mux_sel, {poss[i], negs[i], i < 2, i < 2});
    end
    apb(1, `ACC_OFS_INSEL, 32'hFFFF_FFFF);
    apb(0, `ACC_OFS_INSEL, '0); chk(rd, 32'h0000_1F1F);
    $display("test mux done");
  endtask
  // count codes 0 to 11, divide code following the low three bits of the count code
  task t_accum();
    int c, n;
    logic [31:0] exp;
    for (int k = 0; k < 12; k++) begin
      c = (k > 10) ? 1 : (1 << k);
      exp = ((c * 2048 + c * (c - 1) / 2) >> (k & 7)) & 32'h003F_FFFF;
      apb(1, `ACC_OFS_ACCUM, k[6:0] | ((k & 7) << 4));
      apb(0, `ACC_OFS_ACCUM, '0); chk(rd, k | ((k & 7) << 4));
      @(posedge pclk); go <= 1'b1; cnt <= c[10:0];
      @(posedge pclk); go <= 1'b0;
      n = 0;
      rd = '0;
      while (rd[0] !== 1'b1 && n < 400) begin
        apb(0, `ACC_OFS_STATUS, '0);
        n++;
      end
      chk(rd[0], 1'b1);
      // full 22-bit result read, so no resolution change is needed
      apb(0, `ACC_OFS_RESULT, '0);
      chk(rd, exp);
      apb(0, `ACC_OFS_STATUS, '0); chk(rd[0], 1'b0);
    end
    $display("test accumulate done");
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_mux();
    t_accum();
    print_verdict();
  end
endmodule
